// ---- verilog/dpw_pkg.sv ----
// Behaviour
// - The 8-bit wiper code sits in bits 11 to 4 of the 16-bit position word, so the host shifts it left by four.
// - The wiper code is unsigned binary and bits 15 to 12 and 3 to 0 are ignored on write.
// - A write to the position register makes the new code the active wiper setting at once.
// - The position register sits at 21h and resets to 0000h.
// - A read/write first scratch byte sits at 25h, left-aligned in bits 11 to 4, reset to zero.
// - A read/write second scratch byte sits at 26h with the same layout, reset to zero.
// - The device answers on one of four target addresses chosen by the address-select pin.
// - Writing 0x00 then 0x10 to the protection register at D3h starts a non-volatile store.
// - Stored settings survive power loss and the wiper is restored from storage after power-up.
// - While a store or load runs the device reports busy and refuses writes to the potentiometer registers.
// - The store trigger clears itself after the operation and busy stays high throughout the store.
// - With the lock bit set all register writes are refused, and writing 0101 to the unlock key clears the lock.
package dpw_pkg;
  localparam logic [7:0] ADDR_WIPER_SETTING = 8'h21;
  localparam logic [7:0] ADDR_SCRATCH_BYTE_ONE = 8'h25;
  localparam logic [7:0] ADDR_SCRATCH_BYTE_TWO = 8'h26;
  localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'hd1;
  localparam logic [7:0] ADDR_PROTECT = 8'hd3;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int FIELD_LSB = 4;
  localparam int FIELD_MSB = 11;
  localparam int LOCK_BIT = 13;
  localparam int TRIGGER_BIT = 4;
  localparam int RELOAD_BIT = 5;
  localparam int KEY_LSB = 12;
  localparam logic [3:0] UNLOCK_KEY = 4'h5;
  localparam int STORE_TIME_US = 10;
  localparam int CLK_MHZ = 200;
  localparam int STORE_CYCLES = STORE_TIME_US * CLK_MHZ;
  // Base 7-bit target address; arbitrary value
  localparam logic [6:0] TARGET_BASE = 7'h48;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] data;
  } dpw_wr_t;

  typedef struct packed {
    logic [7:0] wiper;
    logic [7:0] one;
    logic [7:0] two;
  } dpw_nv_t;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_IDLE = 3'b010,
    ST_STORE = 3'b100
  } dpw_state_t;
endpackage

// ---- verilog/dpw_regs.sv ----
`timescale 1ns/1ps
module dpw_regs #(
  parameter int STORE_CYC = dpw_pkg::STORE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [1:0] i_addr_select_pin,
  input wire logic i_wr_valid,
  input wire dpw_pkg::dpw_wr_t i_wr,
  input wire logic [7:0] i_rd_addr,
  input wire dpw_pkg::dpw_nv_t i_nv_data,
  output logic [15:0] o_rd_data,
  output logic [6:0] o_target_addr,
  output logic [7:0] o_wiper_code,
  output logic o_store_in_progress,
  output logic o_locked,
  output logic o_nv_we,
  output dpw_pkg::dpw_nv_t o_nv_data
);
  import dpw_pkg::*;

  // The 32-bit counter serves any positive length
  if (STORE_CYC < 1) begin : g_bad_store_cyc
    $error("STORE_CYC must be at least 1");
  end

  dpw_state_t state;
  logic [7:0] wiper_code;
  logic [7:0] scratch_one;
  logic [7:0] scratch_two;
  logic locked;
  logic [31:0] cnt;
  logic [1:0] sel_meta;
  logic [1:0] sel_sync;
  dpw_nv_t nv_shadow;

  // Strap-like pin, synchronised before use
  always_ff @(posedge i_clk_sys) begin
    sel_meta <= i_addr_select_pin;
    sel_sync <= sel_meta;
  end

  wire logic [7:0] wr_field = i_wr.data[FIELD_MSB:FIELD_LSB];
  wire logic busy = (state != ST_IDLE);
  wire logic wr_ok = i_wr_valid && !locked;
  wire logic key_hit = i_wr_valid && (i_wr.addr == ADDR_PROTECT)
    && (i_wr.data[KEY_LSB+3:KEY_LSB] == UNLOCK_KEY);
  wire logic pot_ok = wr_ok && !busy;
  wire logic wr_wiper = pot_ok && (i_wr.addr == ADDR_WIPER_SETTING);
  wire logic wr_one = pot_ok && (i_wr.addr == ADDR_SCRATCH_BYTE_ONE);
  wire logic wr_two = pot_ok && (i_wr.addr == ADDR_SCRATCH_BYTE_TWO);
  wire logic wr_prot = pot_ok && (i_wr.addr == ADDR_PROTECT);
  wire logic start_store = wr_prot && i_wr.data[TRIGGER_BIT];
  wire logic start_load = wr_prot && i_wr.data[RELOAD_BIT] && !i_wr.data[TRIGGER_BIT];
  wire logic set_lock = wr_ok && (i_wr.addr == ADDR_GENERAL_CONFIG) && i_wr.data[LOCK_BIT];
  wire logic cnt_done = (cnt == 32'(STORE_CYC - 1));

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state <= ST_LOAD;
      cnt <= '0;
      wiper_code <= RST_WORD[FIELD_MSB:FIELD_LSB];
      scratch_one <= RST_WORD[FIELD_MSB:FIELD_LSB];
      scratch_two <= RST_WORD[FIELD_MSB:FIELD_LSB];
      locked <= 1'b0;
      nv_shadow <= '0;
    end else begin
      if (set_lock) begin
        locked <= 1'b1;
      end else if (key_hit) begin
        locked <= 1'b0;
      end
      unique case (state)
        ST_LOAD: begin
          // Restore wiper and scratch from storage
          wiper_code <= i_nv_data.wiper;
          scratch_one <= i_nv_data.one;
          scratch_two <= i_nv_data.two;
          state <= ST_IDLE;
        end
        ST_IDLE: begin
          cnt <= '0;
          if (wr_wiper) wiper_code <= wr_field;
          if (wr_one) scratch_one <= wr_field;
          if (wr_two) scratch_two <= wr_field;
          if (start_store) begin
            nv_shadow <= '{wiper: wiper_code, one: scratch_one, two: scratch_two};
            state <= ST_STORE;
          end else if (start_load) begin
            state <= ST_LOAD;
          end
        end
        ST_STORE: begin
          // Trigger self-clears when the count ends
          cnt <= cnt + 32'd1;
          if (cnt_done) state <= ST_IDLE;
        end
      endcase
    end
  end

  wire logic [15:0] rd_wiper = {4'h0, wiper_code, 4'h0};
  wire logic [15:0] rd_one = {4'h0, scratch_one, 4'h0};
  wire logic [15:0] rd_two = {4'h0, scratch_two, 4'h0};
  wire logic rd_hit_wiper = (i_rd_addr == ADDR_WIPER_SETTING);
  wire logic rd_hit_one = (i_rd_addr == ADDR_SCRATCH_BYTE_ONE);
  wire logic rd_hit_two = (i_rd_addr == ADDR_SCRATCH_BYTE_TWO);
  // Unmapped addresses read as zero, never stale data
  wire logic [15:0] next_rd_data = rd_hit_wiper ? rd_wiper :
    rd_hit_one ? rd_one :
    rd_hit_two ? rd_two : 16'h0000;

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  assign o_target_addr = {TARGET_BASE[6:2], sel_sync};
  assign o_wiper_code = wiper_code;
  assign o_store_in_progress = busy;
  assign o_locked = locked;
  assign o_nv_we = (state == ST_STORE) && cnt_done;
  assign o_nv_data = nv_shadow;

  // Own store length count, kept apart from cnt
  logic [31:0] store_len;
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      store_len <= '0;
    end else if (start_store) begin
      store_len <= 32'd1;
    end else if (o_nv_we) begin
      store_len <= '0;
    end else if (store_len != 32'd0) begin
      store_len <= store_len + 32'd1;
    end
  end

  sequence s_store_start;
    start_store;
  endsequence

  sequence s_store_end;
    o_nv_we && o_store_in_progress;
  endsequence

  sequence s_store_idle;
    !o_store_in_progress && !o_nv_we;
  endsequence

  property p_store_busy;
    @(posedge i_clk_sys) disable iff (!i_nrst) s_store_start |=> o_store_in_progress;
  endproperty
  a_store_busy: assert property (p_store_busy) else $error("busy not raised by store");

  property p_wiper_write;
    @(posedge i_clk_sys) disable iff (!i_nrst) wr_wiper |=> o_wiper_code == $past(wr_field);
  endproperty
  a_wiper_write: assert property (p_wiper_write) else $error("wiper not updated");

  property p_busy_block;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      o_store_in_progress && $stable(o_store_in_progress) |=> $stable(o_wiper_code) || $past(state) == ST_LOAD;
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("wiper changed while busy");

  property p_lock_block;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      o_locked && i_wr_valid && i_wr.addr == ADDR_WIPER_SETTING && state == ST_IDLE |=> $stable(o_wiper_code);
  endproperty
  a_lock_block: assert property (p_lock_block) else $error("write accepted while locked");

  property p_scratch_iso;
    @(posedge i_clk_sys) disable iff (!i_nrst) (wr_one || wr_two) |=> $stable(o_wiper_code);
  endproperty
  a_scratch_iso: assert property (p_scratch_iso) else $error("scratch write moved wiper");

  property p_read_fmt;
    @(posedge i_clk_sys) disable iff (!i_nrst) ##1 (o_rd_data[15:12] == 4'h0 && o_rd_data[3:0] == 4'h0);
  endproperty
  a_read_fmt: assert property (p_read_fmt) else $error("don't-care bits not zero");

  property p_unlock;
    @(posedge i_clk_sys) disable iff (!i_nrst) key_hit && !set_lock |=> !o_locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock key ignored");

  property p_target;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      o_target_addr == {TARGET_BASE[6:2], $past(i_addr_select_pin, 2)};
  endproperty
  a_target: assert property (p_target) else $error("target address mismatch");

  property p_store_len;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      o_nv_we |-> store_len == 32'(STORE_CYC);
  endproperty
  a_store_len: assert property (p_store_len) else $error("store length wrong");

  property p_store_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      store_len != 32'd0 |-> o_store_in_progress;
  endproperty
  a_store_hold: assert property (p_store_hold) else $error("busy dropped during store");

  property p_store_clear;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      s_store_end |=> s_store_idle;
  endproperty
  a_store_clear: assert property (p_store_clear) else $error("busy not cleared after store");

  property p_nv_pulse;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      o_nv_we |=> !o_nv_we;
  endproperty
  a_nv_pulse: assert property (p_nv_pulse) else $error("store strobe longer than one cycle");

  property p_snapshot;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      s_store_start |=> o_nv_data == {$past(wiper_code), $past(scratch_one), $past(scratch_two)};
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("store snapshot wrong");

  property p_restore;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      state == ST_LOAD |=> o_wiper_code == $past(i_nv_data.wiper)
        && scratch_one == $past(i_nv_data.one) && scratch_two == $past(i_nv_data.two);
  endproperty
  a_restore: assert property (p_restore) else $error("restore from storage wrong");

  property p_reset_vals;
    @(posedge i_clk_sys)
      !i_nrst |=> o_wiper_code == RST_WORD[FIELD_MSB:FIELD_LSB] && !o_locked && o_store_in_progress
        && scratch_one == RST_WORD[FIELD_MSB:FIELD_LSB] && scratch_two == RST_WORD[FIELD_MSB:FIELD_LSB];
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_rd_wiper;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      rd_hit_wiper |=> o_rd_data == {4'h0, $past(o_wiper_code), 4'h0};
  endproperty
  a_rd_wiper: assert property (p_rd_wiper) else $error("wiper readback wrong");

  property p_rd_one;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      rd_hit_one |=> o_rd_data == {4'h0, $past(scratch_one), 4'h0};
  endproperty
  a_rd_one: assert property (p_rd_one) else $error("first scratch readback wrong");

  property p_rd_two;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      rd_hit_two |=> o_rd_data == {4'h0, $past(scratch_two), 4'h0};
  endproperty
  a_rd_two: assert property (p_rd_two) else $error("second scratch readback wrong");

  property p_rd_unmapped;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      !rd_hit_wiper && !rd_hit_one && !rd_hit_two |=> o_rd_data == 16'h0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_wiper_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      state == ST_IDLE && !wr_wiper |=> $stable(o_wiper_code);
  endproperty
  a_wiper_hold: assert property (p_wiper_hold) else $error("wiper moved without write");

  property p_scratch_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      state == ST_IDLE |=> ($stable(scratch_one) || $past(wr_one)) && ($stable(scratch_two) || $past(wr_two));
  endproperty
  a_scratch_hold: assert property (p_scratch_hold) else $error("scratch moved without write");

  property p_scratch_busy;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      state == ST_STORE |=> $stable(scratch_one) && $stable(scratch_two);
  endproperty
  a_scratch_busy: assert property (p_scratch_busy) else $error("scratch changed while busy");

  property p_lock_all;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      o_locked && i_wr_valid && state == ST_IDLE
        |=> $stable(o_wiper_code) && $stable(scratch_one) && $stable(scratch_two);
  endproperty
  a_lock_all: assert property (p_lock_all) else $error("register changed while locked");

  property p_lock_no_store;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      o_locked && i_wr_valid && i_wr.addr == ADDR_PROTECT && state == ST_IDLE
        |=> !o_store_in_progress;
  endproperty
  a_lock_no_store: assert property (p_lock_no_store) else $error("store started while locked");

  property p_lock_set;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      !o_locked && i_wr_valid && i_wr.addr == ADDR_GENERAL_CONFIG && i_wr.data[LOCK_BIT]
        |=> o_locked;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set");

  property p_load_busy;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      start_load |=> o_store_in_progress;
  endproperty
  a_load_busy: assert property (p_load_busy) else $error("busy not raised by reload");
endmodule

// ---- verification/dpw_host_model.sv ----
`timescale 1ns/1ps
module dpw_host_model (
  input wire logic i_clk_sys,
  output logic o_wr_valid,
  output dpw_pkg::dpw_wr_t o_wr,
  output logic [7:0] o_rd_addr
);
  import dpw_pkg::*;
  initial begin
    o_wr_valid = 1'b0;
    o_wr = '0;
    o_rd_addr = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] msb, input logic [7:0] lsb);
    @(posedge i_clk_sys);
    #1 o_wr_valid = 1'b1;
    o_wr = {a, msb, lsb};
    @(posedge i_clk_sys);
    #1 o_wr_valid = 1'b0;
    // Released bus shows junk, not the last word
    o_wr = ~o_wr;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    #1 o_rd_addr = a;
    @(posedge i_clk_sys);
    #1;
  endtask
endmodule

// ---- verification/tb_digipot_wiper_user_regs.sv ----
`timescale 1ns/1ps
module tb_digipot_wiper_user_regs;
  import dpw_pkg::*;
  logic clk = 0, nrst = 0, wv, bsy, lck, nwe;
  logic [1:0] sel = 0;
  dpw_nv_t nv = '0, nvo;
  dpw_wr_t wr;
  logic [7:0] ra, wc, w;
  logic [15:0] rdd, d;
  logic [6:0] ta;
  logic [7:0] tbl [3] = '{ADDR_WIPER_SETTING, ADDR_SCRATCH_BYTE_ONE, ADDR_SCRATCH_BYTE_TWO};
  logic [15:0] sh [3];
  int n_fail = 0, samples_checked = 0, cyc = 0, i, k;
  always #2.5 clk = ~clk;
  dpw_regs #(.STORE_CYC(4)) i_dut(.i_clk_sys(clk), .i_nrst(nrst), .i_addr_select_pin(sel), .i_wr_valid(wv),
    .i_wr(wr), .i_rd_addr(ra), .i_nv_data(nv), .o_rd_data(rdd), .o_target_addr(ta), .o_wiper_code(wc),
    .o_store_in_progress(bsy), .o_locked(lck), .o_nv_we(nwe), .o_nv_data(nvo));
  dpw_host_model i_host(.i_clk_sys(clk), .o_wr_valid(wv), .o_wr(wr), .o_rd_addr(ra));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string nm);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rst;
    #1 nrst = 0;
    repeat (16) @(posedge clk);
    #1 nrst = 1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) if (++cyc == 20000) begin
    n_fail++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h6f1b7493));
    rst();
    for (i = 0; i < 3; i++) begin
      i_host.rd(tbl[i]);
      chk(rdd, 16'h0, "reset");
      sh[i] = 16'h0;
    end
    w = 8'h0;
    i_host.wr(ADDR_GENERAL_CONFIG, 8'h11, 8'he5);
    for (k = 0; k < 14; k++) begin
      i = k < 2 ? 0 : $urandom_range(2, 0);
      d = k == 0 ? 16'h0940 : (k == 1 ? 16'hffff : 16'($urandom));
      i_host.wr(tbl[i], d[15:8], d[7:0]);
      sh[i] = d & 16'h0ff0;
      if (i == 0) w = d[11:4];
      chk(wc, w, "wiper");
      i_host.rd(tbl[i]);
      chk(rdd, sh[i], "readback");
    end
    i_host.wr(ADDR_PROTECT, 8'h00, 8'h10);
    chk(bsy, 1'b1, "busy");
    i_host.wr(ADDR_WIPER_SETTING, 8'h0a, 8'hb0);
    chk(wc, w, "write while busy");
    for (k = 0; k < 20 && nwe !== 1'b1; k++) @(posedge clk) #1;
    chk(nwe, 1'b1, "store pulse");
    chk(nvo, {w, sh[1][11:4], sh[2][11:4]}, "snapshot");
    repeat (2) @(posedge clk);
    #1 chk(bsy, 1'b0, "busy end");
    i_host.wr(ADDR_GENERAL_CONFIG, 8'h20, 8'h00);
    chk(lck, 1'b1, "lock");
    i_host.wr(ADDR_WIPER_SETTING, 8'h05, 8'h50);
    chk(wc, w, "locked write");
    i_host.wr(ADDR_PROTECT, 8'h50, 8'h00);
    chk(lck, 1'b0, "unlock");
    i_host.wr(ADDR_WIPER_SETTING, 8'h05, 8'h50);
    chk(wc, 8'h55, "unlocked write");
    for (k = 0; k < 4; k++) begin
      sel = k[1:0];
      repeat (3) @(posedge clk);
      #1 chk(ta, {TARGET_BASE[6:2], sel}, "target");
    end
    nv = 24'($urandom);
    i_host.wr(ADDR_PROTECT, 8'h00, 8'h20);
    chk(bsy, 1'b1, "load busy");
    @(posedge clk) #1 chk(wc, nv.wiper, "reload");
    nv = ~nv;
    rst();
    chk(wc, nv.wiper, "restore");
    i_host.rd(ADDR_SCRATCH_BYTE_TWO);
    chk(rdd, {4'h0, nv.two, 4'h0}, "restore byte");
    print_verdict();
  end
endmodule
